// file: logic/ram_readout_params.svh
`ifndef RAM_READOUT_PARAMS_SVH
`define RAM_READOUT_PARAMS_SVH

// System register encoding fields
`define SYSREG_OP0_VAL        2'h3
`define SYSREG_OP1_VAL        3'h6
`define SYSREG_CRN_VAL        4'hF
`define SYSREG_CRM_INSTR      4'h0
`define SYSREG_CRM_DATA       4'h1
`define SYSREG_CRM_RANDOM     4'h3
`define SYSREG_OP2_WORD0      3'h0
`define SYSREG_OP2_WORD1      3'h1
`define SYSREG_OP2_WORD2      3'h2
`define SYSREG_OP2_BASE       3'h0
`define SYSREG_OP2_REQ_ID     3'h1

// Exception level of full access
`define EL_HIGHEST            2'h3

// Random source register fields
`define RND_BASE_RESET        64'h0000000000000000
`define RND_REQ_ID_RESET      64'h0000000000000000
`define RND_BASE_ADDR_HI      47
`define RND_BASE_ADDR_LO      16
`define RND_NONSECURE_BIT     52
`define RND_REQ_ID_HI         10
`define RND_BASE_WMASK        64'h0010FFFFFFFF0000
`define RND_REQ_ID_WMASK      64'h00000000000007FF

// Readout bank
`define READOUT_WORDS         3

`endif

// file: logic/ram_readout_pkg.sv
package ram_readout_pkg;

   typedef enum logic [1:0]
   {
      SIDE_INSTR = 2'h0,
      SIDE_DATA  = 2'h1
   } readout_side_t;

   typedef enum logic [3:0]
   {
      SEL_NONE    = 4'h0,
      SEL_INSTR0  = 4'h1,
      SEL_INSTR1  = 4'h2,
      SEL_INSTR2  = 4'h3,
      SEL_DATA0   = 4'h4,
      SEL_DATA1   = 4'h5,
      SEL_DATA2   = 4'h6,
      SEL_RBASE   = 4'h7,
      SEL_RREQID  = 4'h8
   } reg_sel_t;

   typedef enum logic [1:0]
   {
      RND_IDLE = 2'h0,
      RND_REQ  = 2'h1
   } rnd_state_t;

endpackage

// file: logic/readout_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "ram_readout_params.svh"

module readout_bank
#(
   parameter int WORDS = `READOUT_WORDS,
   parameter int WIDTH = 64
)
(
   input  wire logic                     clk_sys_in,
   input  wire logic                     resetn_in,
   input  wire logic                     load_in,
   input  wire logic [WORDS*WIDTH-1:0]   load_data_in,
   input  wire logic [1:0]               rd_word_in,
   output var  logic [WIDTH-1:0]         rd_data_out
);

   typedef struct packed
   {
      logic [WORDS-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rd;
   } bank_state_t;

   bank_state_t st_r;
   bank_state_t st_nxt;

   initial
   begin
      if (WORDS < 1 || WORDS > 4)
         $error("readout_bank: WORDS out of range");
   end

   always_comb
   begin
      st_nxt = st_r;
      // Only a completed index operation loads the bank
      if (load_in)
         st_nxt.mem = load_data_in;
      st_nxt.rd = '0;
      for (int i = 0; i < WORDS; i++)
      begin
         if (rd_word_in == 2'(i))
            st_nxt.rd = st_r.mem[i];
      end
   end

   // Contents have no defined reset value
   always_ff @(posedge clk_sys_in)
   begin
      st_r <= st_nxt;
   end

   assign rd_data_out = st_r.rd;

endmodule
`default_nettype wire

// file: logic/random_addr_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "ram_readout_params.svh"

module random_addr_gen
(
   input  wire logic          clk_sys_in,
   input  wire logic          resetn_in,
   input  wire logic          req_in,
   input  wire logic          reseed_in,
   input  wire logic [63:0]   base_in,
   input  wire logic [63:0]   req_id_in,
   output var  logic          valid_out,
   output var  logic [47:0]   addr_out,
   output var  logic          nonsecure_out
);

   import ram_readout_pkg::*;

   typedef struct packed
   {
      rnd_state_t  state;
      logic [47:0] addr;
      logic        ns;
   } addr_state_t;

   addr_state_t st_r;
   addr_state_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.state = RND_IDLE;
      if (req_in)
      begin
         st_nxt.state = RND_REQ;
         st_nxt.addr = {base_in[`RND_BASE_ADDR_HI:`RND_BASE_ADDR_LO],
                        req_id_in[`RND_REQ_ID_HI:0], reseed_in, 4'h0};
         st_nxt.ns = base_in[`RND_NONSECURE_BIT];
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
         st_r <= '{state: RND_IDLE, addr: 48'h0, ns: 1'b0};
      else
         st_r <= st_nxt;
   end

   assign valid_out     = (st_r.state == RND_REQ);
   assign addr_out      = st_r.addr;
   assign nonsecure_out = st_r.ns;

endmodule
`default_nettype wire

// file: logic/ram_readout_debug_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "ram_readout_params.svh"

module ram_readout_debug_regs
#(
   parameter int WIDTH = 64
)
(
   input  wire logic                   clk_sys_in,
   input  wire logic                   resetn_in,
   // System register access
   input  wire logic                   sreg_valid_in,
   input  wire logic                   sreg_write_in,
   input  wire logic [1:0]             sreg_op0_in,
   input  wire logic [2:0]             sreg_op1_in,
   input  wire logic [3:0]             sreg_crn_in,
   input  wire logic [3:0]             sreg_crm_in,
   input  wire logic [2:0]             sreg_op2_in,
   input  wire logic [1:0]             sreg_el_in,
   input  wire logic [WIDTH-1:0]       sreg_wdata_in,
   output logic                        sreg_done_out,
   output logic                        sreg_undef_out,
   output logic [WIDTH-1:0]            sreg_rdata_out,
   // Index operation capture
   input  wire logic                   instr_load_in,
   input  wire logic [3*WIDTH-1:0]     instr_load_data_in,
   input  wire logic                   data_load_in,
   input  wire logic [3*WIDTH-1:0]     data_load_data_in,
   // Random number access
   input  wire logic                   rnd_req_in,
   input  wire logic                   rnd_reseed_in,
   output logic                        rnd_valid_out,
   output logic [47:0]                 rnd_addr_out,
   output logic                        rnd_nonsecure_out,
   output logic [WIDTH-1:0]            random_source_base_out,
   output logic [WIDTH-1:0]            random_source_requester_id_out
);

   import ram_readout_pkg::*;

   initial
   begin
      if (WIDTH != 64)
         $error("ram_readout_debug_regs: WIDTH must be 64");
   end

   typedef struct packed
   {
      logic             pend;
      reg_sel_t         sel;
      logic             done;
      logic             undef;
      logic [WIDTH-1:0] rdata;
      logic [WIDTH-1:0] rbase;
      logic [WIDTH-1:0] rreqid;
   } regs_state_t;

   regs_state_t st_r;
   regs_state_t st_nxt;

   logic [WIDTH-1:0] instr_rd;
   logic [WIDTH-1:0] data_rd;
   logic [1:0]       word_sel;
   reg_sel_t         dec_sel;

   // Decode encoding to a register select
   function automatic reg_sel_t decode_sel(input logic [1:0] op0, input logic [2:0] op1,
                                           input logic [3:0] crn, input logic [3:0] crm,
                                           input logic [2:0] op2);
      reg_sel_t s;
      s = SEL_NONE;
      if (op0 == `SYSREG_OP0_VAL && op1 == `SYSREG_OP1_VAL && crn == `SYSREG_CRN_VAL)
      begin
         if (crm == `SYSREG_CRM_INSTR)
         begin
            if (op2 == `SYSREG_OP2_WORD0)
               s = SEL_INSTR0;
            else if (op2 == `SYSREG_OP2_WORD1)
               s = SEL_INSTR1;
            else if (op2 == `SYSREG_OP2_WORD2)
               s = SEL_INSTR2;
         end
         else if (crm == `SYSREG_CRM_DATA)
         begin
            if (op2 == `SYSREG_OP2_WORD0)
               s = SEL_DATA0;
            else if (op2 == `SYSREG_OP2_WORD1)
               s = SEL_DATA1;
            else if (op2 == `SYSREG_OP2_WORD2)
               s = SEL_DATA2;
         end
         else if (crm == `SYSREG_CRM_RANDOM)
         begin
            if (op2 == `SYSREG_OP2_BASE)
               s = SEL_RBASE;
            else if (op2 == `SYSREG_OP2_REQ_ID)
               s = SEL_RREQID;
         end
      end
      return s;
   endfunction

   function automatic logic is_readout(input reg_sel_t s);
      return (s >= SEL_INSTR0) && (s <= SEL_DATA2);
   endfunction

   assign dec_sel  = decode_sel(sreg_op0_in, sreg_op1_in, sreg_crn_in, sreg_crm_in,
                                sreg_op2_in);
   assign word_sel = sreg_op2_in[1:0];

   readout_bank #(.WORDS(`READOUT_WORDS), .WIDTH(WIDTH)) u_instr_bank
   (
      .clk_sys_in   (clk_sys_in),
      .resetn_in    (resetn_in),
      .load_in      (instr_load_in),
      .load_data_in (instr_load_data_in),
      .rd_word_in   (word_sel),
      .rd_data_out  (instr_rd)
   );

   readout_bank #(.WORDS(`READOUT_WORDS), .WIDTH(WIDTH)) u_data_bank
   (
      .clk_sys_in   (clk_sys_in),
      .resetn_in    (resetn_in),
      .load_in      (data_load_in),
      .load_data_in (data_load_data_in),
      .rd_word_in   (word_sel),
      .rd_data_out  (data_rd)
   );

   random_addr_gen u_rnd
   (
      .clk_sys_in    (clk_sys_in),
      .resetn_in     (resetn_in),
      .req_in        (rnd_req_in),
      .reseed_in     (rnd_reseed_in),
      .base_in       (st_r.rbase),
      .req_id_in     (st_r.rreqid),
      .valid_out     (rnd_valid_out),
      .addr_out      (rnd_addr_out),
      .nonsecure_out (rnd_nonsecure_out)
   );

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pend  = 1'b0;
      st_nxt.done  = 1'b0;
      st_nxt.undef = 1'b0;
      st_nxt.rdata = '0;
      // Stage 1: take the access
      if (sreg_valid_in)
      begin
         if (sreg_el_in != `EL_HIGHEST || dec_sel == SEL_NONE)
         begin
            st_nxt.done  = 1'b1;
            st_nxt.undef = 1'b1;
         end
         else if (sreg_write_in)
         begin
            st_nxt.done = 1'b1;
            if (dec_sel == SEL_RBASE)
               st_nxt.rbase = sreg_wdata_in & `RND_BASE_WMASK;
            else if (dec_sel == SEL_RREQID)
               st_nxt.rreqid = sreg_wdata_in & `RND_REQ_ID_WMASK;
            else
               st_nxt.undef = is_readout(dec_sel);
         end
         else if (is_readout(dec_sel))
         begin
            st_nxt.pend = 1'b1;
            st_nxt.sel  = dec_sel;
         end
         else
         begin
            st_nxt.done  = 1'b1;
            st_nxt.rdata = (dec_sel == SEL_RBASE) ? st_r.rbase : st_r.rreqid;
         end
      end
      // Stage 2: readout bank data now registered
      if (st_r.pend)
      begin
         st_nxt.done  = 1'b1;
         st_nxt.rdata = (st_r.sel <= SEL_INSTR2) ? instr_rd : data_rd;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         st_r <= '{pend: 1'b0, sel: SEL_NONE, done: 1'b0, undef: 1'b0, rdata: '0,
                   rbase: `RND_BASE_RESET, rreqid: `RND_REQ_ID_RESET};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign sreg_done_out                  = st_r.done;
   assign sreg_undef_out                 = st_r.undef;
   assign sreg_rdata_out                 = st_r.rdata;
   assign random_source_base_out         = st_r.rbase;
   assign random_source_requester_id_out = st_r.rreqid;

endmodule
`default_nettype wire

// file: sim/ram_readout_debug_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ram_readout_debug_regs_sva
(
   input wire logic        clk_sys_in,
   input wire logic        resetn_in,
   input wire logic        sreg_valid_in,
   input wire logic        sreg_write_in,
   input wire logic [1:0]  sreg_op0_in,
   input wire logic [2:0]  sreg_op1_in,
   input wire logic [3:0]  sreg_crn_in,
   input wire logic [3:0]  sreg_crm_in,
   input wire logic [2:0]  sreg_op2_in,
   input wire logic [1:0]  sreg_el_in,
   input wire logic        sreg_done_out,
   input wire logic        sreg_undef_out,
   input wire logic [63:0] sreg_rdata_out,
   input wire logic        rnd_req_in,
   input wire logic        rnd_reseed_in,
   input wire logic        rnd_valid_out,
   input wire logic [47:0] rnd_addr_out,
   input wire logic        rnd_nonsecure_out,
   input wire logic [63:0] random_source_base_out,
   input wire logic [63:0] random_source_requester_id_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   wire sp = sreg_op0_in == 2'h3 && sreg_op1_in == 3'h6 && sreg_crn_in == 4'hF;
   wire ro = sp && sreg_crm_in < 4'h2 && sreg_op2_in < 3'h3;
   wire rq = sreg_valid_in && !sreg_write_in && sreg_el_in == 2'h3 && ro;
   property p_low_el;
      sreg_valid_in && sreg_el_in != 2'h3 |=> sreg_done_out && sreg_undef_out;
   endproperty
   a_low_el: assert property (p_low_el) else $error("low level access not refused");
   property p_undef_zero;
      sreg_undef_out |-> sreg_done_out && sreg_rdata_out == 64'h0;
   endproperty
   a_undef_zero: assert property (p_undef_zero) else $error("refused access with data");
   property p_ro_read;
      rq |=> !sreg_done_out ##1 (sreg_done_out && !sreg_undef_out);
   endproperty
   a_ro_read: assert property (p_ro_read) else $error("readout read not answered");
   property p_ro_write;
      sreg_valid_in && sreg_write_in && ro |=> sreg_undef_out;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("readout write accepted");
   property p_rnd_valid;
      rnd_req_in |=> rnd_valid_out;
   endproperty
   a_rnd_valid: assert property (p_rnd_valid) else $error("random request lost");
   property p_rnd_addr;
      rnd_req_in |=> rnd_addr_out == {$past(random_source_base_out[47:16]),
         $past(random_source_requester_id_out[10:0]), $past(rnd_reseed_in), 4'h0};
   endproperty
   a_rnd_addr: assert property (p_rnd_addr) else $error("random address wrong");
   property p_rnd_ns;
      rnd_req_in |=> rnd_nonsecure_out == $past(random_source_base_out[52]);
   endproperty
   a_rnd_ns: assert property (p_rnd_ns) else $error("random security wrong");
   property p_rsv;
      (random_source_base_out & 64'hFFEF_0000_0000_FFFF) == 64'h0 &&
         random_source_requester_id_out[63:11] == 53'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   c_read: cover property (sreg_done_out && !sreg_undef_out && sreg_rdata_out != 64'h0);
   c_undef: cover property (sreg_undef_out);
   c_rnd: cover property (rnd_valid_out && rnd_addr_out[4]);
endmodule
bind ram_readout_debug_regs ram_readout_debug_regs_sva u_sva
(
   .clk_sys_in, .resetn_in, .sreg_valid_in, .sreg_write_in, .sreg_op0_in, .sreg_op1_in,
   .sreg_crn_in, .sreg_crm_in, .sreg_op2_in, .sreg_el_in, .sreg_done_out, .sreg_undef_out,
   .sreg_rdata_out, .rnd_req_in, .rnd_reseed_in, .rnd_valid_out, .rnd_addr_out,
   .rnd_nonsecure_out, .random_source_base_out, .random_source_requester_id_out
);
`default_nettype wire

// file: sim/ram_readout_debug_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module ram_readout_debug_regs_test;
   logic         clk = 1'b0;
   logic         rstn = 1'b0;
   logic         vld = 1'b0;
   logic         wr = 1'b0;
   logic         il = 1'b0;
   logic         dl = 1'b0;
   logic         rq = 1'b0;
   logic         rs = 1'b0;
   logic [1:0]   el = 2'h3;
   logic [3:0]   crm = 4'h0;
   logic [2:0]   op2 = 3'h0;
   logic [1:0]   op0 = 2'h3;
   logic [2:0]   op1 = 3'h6;
   logic [3:0]   crn = 4'hF;
   logic [63:0]  wd = 64'h0;
   logic [191:0] idat = {{8{8'hA2}}, {8{8'hA1}}, {8{8'hA0}}};
   logic [191:0] ddat = {{8{8'hD2}}, {8{8'hD1}}, {8{8'hD0}}};
   logic         done, undef, rv, ns, un;
   logic [63:0]  rdata, bo, io, rd;
   logic [47:0]  ra;
   int           errors = 0;
   int           compares = 0;

   initial forever #2.5 clk = ~clk;

   ram_readout_debug_regs DUT
   (
      .clk_sys_in(clk), .resetn_in(rstn), .sreg_valid_in(vld), .sreg_write_in(wr),
      .sreg_op0_in(op0), .sreg_op1_in(op1), .sreg_crn_in(crn), .sreg_crm_in(crm),
      .sreg_op2_in(op2), .sreg_el_in(el), .sreg_wdata_in(wd), .sreg_done_out(done),
      .sreg_undef_out(undef), .sreg_rdata_out(rdata), .instr_load_in(il),
      .instr_load_data_in(idat), .data_load_in(dl), .data_load_data_in(ddat),
      .rnd_req_in(rq), .rnd_reseed_in(rs), .rnd_valid_out(rv), .rnd_addr_out(ra),
      .rnd_nonsecure_out(ns), .random_source_base_out(bo),
      .random_source_requester_id_out(io)
   );

   task chk(input logic [63:0] s, input logic [63:0] e);
      compares++;
      if (s !== e)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task finish_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task acc(input logic w, input logic [1:0] e, input logic [3:0] m, input logic [2:0] o,
            input logic [63:0] d);
      int n;
      n = 0;
      @(negedge clk);
      vld = 1'b1;
      wr = w;
      el = e;
      crm = m;
      op2 = o;
      wd = d;
      @(negedge clk);
      vld = 1'b0;
      while (done !== 1'b1 && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      chk({63'h0, done}, 64'h1);
      rd = rdata;
      un = undef;
   endtask

   task rnd(input logic s, input logic [47:0] ea, input logic en);
      @(negedge clk);
      rq = 1'b1;
      rs = s;
      @(negedge clk);
      rq = 1'b0;
      chk({63'h0, rv}, 64'h1);
      chk({16'h0, ra}, {16'h0, ea});
      chk({63'h0, ns}, {63'h0, en});
   endtask

   task t_ram;
      @(negedge clk);
      il = 1'b1;
      dl = 1'b1;
      @(negedge clk);
      il = 1'b0;
      dl = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         acc(1'b0, 2'h3, 4'(i / 3), 3'(i % 3), 64'h0);
         chk({63'h0, un}, 64'h0);
         chk(rd, i < 3 ? idat[64*i +: 64] : ddat[64*(i-3) +: 64]);
      end
      acc(1'b1, 2'h3, 4'h0, 3'h1, 64'h0);
      chk({63'h0, un}, 64'h1);
      acc(1'b0, 2'h3, 4'h0, 3'h1, 64'h0);
      chk(rd, idat[127:64]);
   endtask

   task t_el;
      for (int e = 0; e < 3; e++)
      begin
         acc(1'b0, 2'(e), 4'h1, 3'h2, 64'h0);
         chk({63'h0, un}, 64'h1);
         chk(rd, 64'h0);
      end
      acc(1'b1, 2'h1, 4'h3, 3'h0, 64'hFFFF);
      chk(bo, 64'h0);
      acc(1'b0, 2'h3, 4'h2, 3'h0, 64'h0);
      chk({63'h0, un}, 64'h1);
      op1 = 3'h5;
      acc(1'b0, 2'h3, 4'h0, 3'h0, 64'h0);
      chk({63'h0, un}, 64'h1);
      op1 = 3'h6;
      op0 = 2'h1;
      acc(1'b0, 2'h3, 4'h1, 3'h0, 64'h0);
      chk({63'h0, un}, 64'h1);
      op0 = 2'h3;
      crn = 4'hE;
      acc(1'b0, 2'h3, 4'h1, 3'h0, 64'h0);
      chk({63'h0, un}, 64'h1);
      crn = 4'hF;
   endtask

   task t_rnd;
      acc(1'b1, 2'h3, 4'h3, 3'h0, '1);
      chk(bo, 64'h0010_FFFF_FFFF_0000);
      acc(1'b0, 2'h3, 4'h3, 3'h0, 64'h0);
      chk(rd, 64'h0010_FFFF_FFFF_0000);
      acc(1'b1, 2'h3, 4'h3, 3'h1, '1);
      chk(io, 64'h7FF);
      rnd(1'b0, 48'hFFFF_FFFF_FFE0, 1'b1);
      rnd(1'b1, 48'hFFFF_FFFF_FFF0, 1'b1);
      acc(1'b1, 2'h3, 4'h3, 3'h0, 64'h0000_1234_5678_0000);
      acc(1'b1, 2'h3, 4'h3, 3'h1, 64'h555);
      rnd(1'b0, 48'h1234_5678_AAA0, 1'b0);
      rnd(1'b1, 48'h1234_5678_AAB0, 1'b0);
   endtask

   initial
   begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      chk(bo, 64'h0);
      chk(io, 64'h0);
      t_ram;
      t_el;
      t_rnd;
      finish_test;
   end

   initial
   begin
      #20000;
      errors++;
      finish_test;
   end
endmodule
`default_nettype wire
